// ### rtl/segment_lcd_frame_waveform_gen.sv
// Overview of operation
// - static frame = source/(4*1*(prescale+1)*32); half = source/(2*2*(prescale+1)*32).
// - third frame = source/(1*3*(prescale+1)*32); quarter = source/(1*4*(prescale+1)*32).
// - timing source is system clock/256, timer1 crystal or slow internal clock.
// - backplane k reads pixel words 3k..3k+2; column n at word n/8, bit n%8.
// - backplane lines carry their time slice; columns carry the active slot's data.
// - backplane minus column averages zero volts over each waveform cycle.
// - set pixel gets the high rms level, cleared pixel the low one.
// - type A flips phase inside each slot; type B flips at each frame.
// - sleep with system clock/256 source stops display at once, any sleep setting.
// - interrupt when display goes from active to inactive.
// - frame interrupt from the frame generator for type B update timing.
// - multiplex 00 static, 01 half, 10 third, 11 quarter backplanes.
// - frame starts at backplane 0; frame interrupt once its data is fetched.
// - no frame interrupt in type A, nor in type B static.
// - type B multiplexed pixel writes outside the window while running are dropped and flag a write error.
`timescale 1ns/1ps
`include "lcd_consts.svh"

module segment_lcd_frame_waveform_gen import lcd_pkg::*; (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // register bus
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // timing sources and sleep
    input  wire logic        timer1_crystal_clock,
    input  wire logic        slow_internal_clock,
    input  wire logic        sleep_req,
    // glass and interrupt
    output drive_type        lcd_drive,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] sub_last(input logic [1:0] mux);
        case (mux)
            2'h0:    sub_last = 2'h3;
            2'h1:    sub_last = 2'h1;
            default: sub_last = 2'h0;
        endcase
    endfunction

    function automatic logic half_phase(input logic [1:0] mux, input logic [1:0] sub,
                                        input logic [4:0] blk);
        case (mux)
            2'h0:    half_phase = sub[1];
            2'h1:    half_phase = sub[0];
            default: half_phase = blk[4];
        endcase
    endfunction

    function automatic drive_type make_drive(input logic [1:0] mux, input logic [1:0] slot,
                                             input logic ph, input logic [23:0] row);
        drive_type d;
        d = '0;
        for (int k = 0; k < 4; k++) begin
            if (k == slot) begin
                d.backplane_line[k] = ph ? `LVL_0 : `LVL_3;
            end else if (k <= mux && mux != 2'h0) begin
                d.backplane_line[k] = ph ? `LVL_2 : `LVL_1;
            end
        end
        for (int n = 0; n < 24; n++) begin
            if (row[n]) begin
                d.pixel_column_drive[n] = ph ? `LVL_3 : `LVL_0;
            end else if (mux == 2'h0) begin
                d.pixel_column_drive[n] = ph ? `LVL_0 : `LVL_3;
            end else begin
                d.pixel_column_drive[n] = ph ? `LVL_1 : `LVL_2;
            end
        end
        make_drive = d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [7:0]  pixel_bits [12];
    control_type display_control_reg;
    logic [3:0]  frame_prescale;
    logic        write_error_flag;
    logic [1:0]  int_status;
    logic [1:0]  int_mask;
    state_type   state;
    logic [2:0]  t1_sync;
    logic [2:0]  slow_sync;
    logic        t1_level;
    logic        slow_level;
    logic [7:0]  sys_cnt;
    logic [3:0]  pre_cnt;
    logic [4:0]  blk_cnt;
    logic [1:0]  sub_cnt;
    logic [1:0]  slot;
    logic        frame_odd;
    logic        win_open;
    logic [23:0] row;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire logic        wr_go    = write && !waitrequest && byteenable[0];
    wire logic        rd_go    = read && waitrequest;
    wire logic [7:0]  wbyte    = writedata[7:0];
    wire logic        pix_sel  = address <= `REG_PIXEL_LAST;
    wire logic [3:0]  pix_idx  = pix_sel ? address[3:0] : 4'h0;
    wire logic        display_active_flag = state == st_run;
    wire logic        type_b_mux = display_control_reg.waveform_type_select &&
                                   display_control_reg.multiplex_select != 2'h0;
    wire logic        pix_ok   = !(display_active_flag && type_b_mux && !win_open);
    wire logic        pix_wr   = wr_go && pix_sel && pix_ok;
    wire logic        pix_err  = wr_go && pix_sel && !pix_ok;
    wire logic [1:0]  int_clr  = (wr_go && address == `REG_INT_STATUS) ? wbyte[1:0] : 2'h0;
    wire logic        write_error_flag_clr = wr_go && address == `REG_STATUS && wbyte[`STAT_WRITE_ERROR_FLAG_BIT];
    wire logic [7:0]  status_byte = {6'h00, write_error_flag, display_active_flag};
    wire logic [7:0]  next_rdata =
        pix_sel                     ? pixel_bits[pix_idx] :
        address == `REG_CONTROL     ? display_control_reg :
        address == `REG_PRESCALE    ? {4'h0, frame_prescale} :
        address == `REG_STATUS      ? status_byte :
        address == `REG_INT_STATUS  ? {6'h00, int_status} :
        address == `REG_INT_MASK    ? {6'h00, int_mask} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timing source selection

    wire logic t1_next   = (t1_sync[2] == t1_sync[1]) ? t1_sync[2] : t1_level;
    wire logic slow_next = (slow_sync[2] == slow_sync[1]) ? slow_sync[2] : slow_level;
    wire logic src_tick  =
        display_control_reg.clock_source == `SRC_SYS_DIV ? sys_cnt == `SYS_DIV_LAST :
        display_control_reg.clock_source == `SRC_TIMER1  ? t1_next && !t1_level :
        display_control_reg.clock_source == `SRC_SLOW    ? slow_next && !slow_level :
        1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // frame generator

    wire logic [1:0] mux        = display_control_reg.multiplex_select;
    wire logic       pre_wrap   = display_active_flag && src_tick && pre_cnt == frame_prescale;
    wire logic       blk_wrap   = pre_wrap && blk_cnt == `BLOCK_LAST;
    wire logic       slot_end   = blk_wrap && sub_cnt == sub_last(mux);
    wire logic       frame_end  = slot_end && slot == mux;
    wire logic [1:0] next_slot  = frame_end ? 2'h0 : slot + 2'h1;
    wire logic       halt_sleep = sleep_req && (display_control_reg.sleep_shutdown_enable ||
                                  display_control_reg.clock_source == `SRC_SYS_DIV);
    // a start between source ticks would shorten the first half slot and leave
    // a dc residue on all but cleared static pixels, so the generator starts on a tick
    wire logic       start_req  = state == st_idle && display_control_reg.enable && !halt_sleep;
    wire logic       go         = start_req && src_tick;
    wire logic       stop       = display_active_flag &&
                                  (halt_sleep || (frame_end && !display_control_reg.enable));
    wire logic       frame_evt  = slot_end && !frame_end && next_slot == mux &&
                                  type_b_mux;
    wire logic       phase      = display_control_reg.waveform_type_select ? frame_odd :
                                  half_phase(mux, sub_cnt, blk_cnt);
    wire logic [3:0][23:0] rows;

    for (genvar k = 0; k < 4; k++) begin : g_rows
        assign rows[k] = {pixel_bits[3*k+2], pixel_bits[3*k+1], pixel_bits[3*k]};
    end

    wire drive_type  next_drive = display_active_flag ? make_drive(mux, slot, phase, row) : '0;
    wire logic [1:0] evts       = {frame_evt, stop};
    wire logic [1:0] next_int_status = (int_status & ~int_clr) | evts;

    ////////////////////////////////////////////////////////////////////////////
    // register bus slave

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (rd_go) begin
                readdata <= {24'h00_0000, next_rdata};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 12; i++) begin
                pixel_bits[i] <= `PIXEL_RESET;
            end
        end else if (pix_wr) begin
            pixel_bits[pix_idx] <= wbyte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            display_control_reg <= `CONTROL_RESET;
            frame_prescale      <= `PRESCALE_RESET;
            int_mask            <= `INT_RESET;
        end else if (wr_go) begin
            if (address == `REG_CONTROL) begin
                display_control_reg <= wbyte;
            end
            if (address == `REG_PRESCALE) begin
                frame_prescale <= wbyte[3:0];
            end
            if (address == `REG_INT_MASK) begin
                int_mask <= wbyte[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags and interrupt

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_status       <= `INT_RESET;
            write_error_flag <= 1'b0;
            irq              <= 1'b0;
        end else begin
            int_status       <= next_int_status;
            write_error_flag <= (write_error_flag && !write_error_flag_clr) || pix_err;
            irq              <= |(next_int_status & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and system divider

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            t1_sync    <= 3'h0;
            slow_sync  <= 3'h0;
            t1_level   <= 1'b0;
            slow_level <= 1'b0;
            sys_cnt    <= 8'h00;
        end else begin
            t1_sync    <= {t1_sync[1:0], timer1_crystal_clock};
            slow_sync  <= {slow_sync[1:0], slow_internal_clock};
            t1_level   <= t1_next;
            slow_level <= slow_next;
            sys_cnt    <= sys_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run state

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: if (go) begin
                    state <= st_run;
                end
                st_run: if (stop) begin
                    state <= st_idle;
                end
                default: state <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescale, divide-by-32, slot and phase counters

    always_ff @(posedge ref_clk) begin
        if (srst || go) begin
            pre_cnt   <= 4'h0;
            blk_cnt   <= 5'h00;
            sub_cnt   <= 2'h0;
            slot      <= 2'h0;
            frame_odd <= 1'b0;
        end else if (src_tick && display_active_flag) begin
            pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
            if (pre_wrap) begin
                blk_cnt <= blk_cnt + 5'h01;
            end
            if (slot_end) begin
                sub_cnt <= 2'h0;
                slot    <= next_slot;
            end else if (blk_wrap) begin
                sub_cnt <= sub_cnt + 2'h1;
            end
            if (frame_end) begin
                frame_odd <= !frame_odd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data fetch, write window and drive outputs

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            row       <= 24'h00_0000;
            win_open  <= 1'b0;
            lcd_drive <= '0;
        end else begin
            if (go) begin
                row <= rows[0];
            end else if (slot_end) begin
                row <= rows[next_slot];
            end
            if (!display_active_flag || frame_end) begin
                win_open <= 1'b0;
            end else if (frame_evt) begin
                win_open <= 1'b1;
            end
            lcd_drive <= next_drive;
        end
    end

endmodule

// ### pkg/lcd_consts.svh
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// register word indices (byte address is four times the index)
`define REG_PIXEL_LAST  5'h0b
`define REG_CONTROL     5'h0c
`define REG_PRESCALE    5'h0d
`define REG_STATUS      5'h0e
`define REG_INT_STATUS  5'h0f
`define REG_INT_MASK    5'h10

// status and interrupt bit positions
`define STAT_ACTIVE_BIT 0
`define STAT_WRITE_ERROR_FLAG_BIT   1
`define INT_SHUT_BIT    0
`define INT_FRAME_BIT   1

// reset values
`define CONTROL_RESET   8'h00
`define PRESCALE_RESET  4'h0
`define PIXEL_RESET     8'h00
`define INT_RESET       2'h0

// timing source codes
`define SRC_SYS_DIV     2'h0
`define SRC_TIMER1      2'h1
`define SRC_SLOW        2'h2

// divider terminal counts
`define SYS_DIV_LAST    8'hff
`define BLOCK_LAST      5'h1f

// drive levels, lowest to highest
`define LVL_0           2'h0
`define LVL_1           2'h1
`define LVL_2           2'h2
`define LVL_3           2'h3

`endif

// ### pkg/lcd_pkg.sv
package lcd_pkg;

    typedef enum logic {
        st_idle,
        st_run
    } state_type;

    typedef struct packed {
        logic       enable;
        logic       spare;
        logic       sleep_shutdown_enable;
        logic       waveform_type_select;
        logic [1:0] clock_source;
        logic [1:0] multiplex_select;
    } control_type;

    typedef struct packed {
        logic [3:0][1:0]  backplane_line;
        logic [23:0][1:0] pixel_column_drive;
    } drive_type;

endpackage

// ### dv/lcd_frame_checker.sv
`timescale 1ns/1ps
`include "lcd_consts.svh"

module lcd_frame_checker import lcd_pkg::*; (
    // clock, reset and register bus
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // sleep, glass and interrupt
    input wire logic        sleep_req,
    input drive_type        lcd_drive,
    input wire logic        irq
);
    logic [7:0] ctrl_sh;
    logic [7:0] pix_sh;
    logic [1:0] mask_sh;
    wire        take_wr = write && !waitrequest && byteenable[0];
    wire  [1:0] bp0     = lcd_drive.backplane_line[0];
    wire  [1:0] col0    = lcd_drive.pixel_column_drive[0];
    wire  [3:0] peak    = {~^lcd_drive.backplane_line[3], ~^lcd_drive.backplane_line[2],
                           ~^lcd_drive.backplane_line[1], ~^bp0};

    // shadow of the written control, pixel and mask values
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_sh <= 8'h00;
            pix_sh  <= 8'h00;
            mask_sh <= 2'h0;
        end else if (take_wr) begin
            if (address == `REG_CONTROL)
                ctrl_sh <= writedata[7:0];
            if (address == 5'h00)
                pix_sh <= writedata[7:0];
            if (address == `REG_INT_MASK)
                mask_sh <= writedata[1:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
    property p_rd_high;
        !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("read data upper bits set");
    property p_sleep_stop;
        sleep_req && ctrl_sh[3:2] == `SRC_SYS_DIV |-> ##[1:2] lcd_drive == '0;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep did not stop glass");
    property p_unused_bp;
        ctrl_sh[1:0] == 2'h0 |-> lcd_drive.backplane_line[3:1] == '0;
    endproperty
    a_unused_bp: assert property (p_unused_bp) else $error("unused backplane driven");
    property p_one_peak;
        ctrl_sh[1:0] == 2'h3 && lcd_drive != '0 |-> $countones(peak) == 1;
    endproperty
    a_one_peak: assert property (p_one_peak) else $error("not one active backplane");
    property p_static_col;
        ctrl_sh[1:0] == 2'h0 && lcd_drive != '0 |-> col0 == (pix_sh[0] ? ~bp0 : bp0);
    endproperty
    a_static_col: assert property (p_static_col) else $error("static column level wrong");
    property p_idle_off;
        !ctrl_sh[7] && lcd_drive == '0 |=> lcd_drive == '0;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("glass driven while off");
    property p_irq_off;
        mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");
endmodule

bind segment_lcd_frame_waveform_gen lcd_frame_checker lcd_frame_checker_i (.ref_clk, .srst,
    .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .sleep_req,
    .lcd_drive, .irq);

// ### dv/lcd_glass_model.sv
`timescale 1ns/1ps

module lcd_glass_model import lcd_pkg::*; (
    // clock and glass lines
    input  wire logic ref_clk,
    input  drive_type lcd_drive,
    // observation
    input  wire logic dc_clear,
    output int        frame_len = 0,
    output int        dc_sum = 0
);
    int         count    = 0;
    logic [1:0] bp0_last = 2'h0;
    wire  [1:0] bp0      = lcd_drive.backplane_line[0];
    wire  [1:0] col0     = lcd_drive.pixel_column_drive[0];

    // frame length between backplane 0 leading edges, net dc of pixel 0/0
    always @(posedge ref_clk) begin
        bp0_last <= bp0;
        count    <= count + 1;
        if (bp0 == 2'h3 && bp0_last != 2'h3) begin
            frame_len <= count + 1;
            count     <= 0;
        end
        dc_sum <= dc_clear ? 0 : dc_sum + int'(bp0) - int'(col0);
    end
endmodule

// ### dv/segment_lcd_frame_waveform_gen_tb_top.sv
`timescale 1ns/1ps
`include "lcd_consts.svh"

module segment_lcd_frame_waveform_gen_tb_top import lcd_pkg::*; ;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'h1;
    logic        timer1_crystal_clock = 1'b0;
    logic        slow_internal_clock = 1'b0;
    logic        sleep_req = 1'b0;
    logic        dc_clear = 1'b0;
    logic [2:0]  tick = 3'h0;
    logic [31:0] rd;
    logic [7:0]  ctl;
    wire  [31:0] readdata;
    wire         waitrequest;
    wire         irq;
    drive_type   lcd_drive;
    int          frame_len;
    int          dc_sum;
    int          exp_len;
    int          errors = 0;
    int          compares = 0;

    always #50 ref_clk = ~ref_clk;
    // timer1 pin ticks every 4 cycles
    always @(posedge ref_clk) begin
        tick                 <= tick + 3'h1;
        timer1_crystal_clock <= tick[1];
        slow_internal_clock  <= tick[2];
    end

    segment_lcd_frame_waveform_gen segment_lcd_frame_waveform_gen_i (.ref_clk, .srst, .address,
        .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .timer1_crystal_clock,
        .slow_internal_clock, .sleep_req, .lcd_drive, .irq);
    lcd_glass_model lcd_glass_model_i (.ref_clk, .lcd_drive, .dc_clear, .frame_len, .dc_sum);

    ////////////////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task give_up(input string what);
        errors++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        tally_and_finish();
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        if (n >= 20)
            give_up("bus");
    endtask

    task poll(input logic [4:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 8'h00);
            n++;
        end while (rd[b] !== v && n < 1500);
        if (n >= 1500)
            give_up("poll");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge ref_clk);
        give_up("run");
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        bus(1'b0, `REG_CONTROL, 8'h00);
        check("control reset", 32'h0, rd);
        bus(1'b1, 5'h1f, 8'hff);
        bus(1'b0, 5'h1f, 8'h00);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, 5'(i), 8'ha5 ^ 8'(i));
            bus(1'b0, 5'(i), 8'h00);
            check("pixel word", 32'(8'ha5 ^ 8'(i)), rd);
            bus(1'b1, 5'(i), 8'(i == 0));
        end
        bus(1'b1, `REG_PRESCALE, 8'h01);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            ctl = {4'h0, ((m == 3) ? `SRC_SLOW : `SRC_TIMER1), 2'(m)};
            exp_len = (m == 3 ? 8 : 4) * 32 * 2 * (m + 1) * (m == 0 ? 4 : (m == 1 ? 2 : 1));
            dc_clear <= 1'b1;
            bus(1'b1, `REG_CONTROL, 8'h80 | ctl);
            dc_clear <= 1'b0;
            repeat (3 * exp_len + 100) @(posedge ref_clk);
            check("frame length", exp_len, frame_len);
            bus(1'b0, `REG_INT_STATUS, 8'h00);
            check("type a frame int", 32'h0, rd);
            bus(1'b1, `REG_CONTROL, ctl);
            poll(`REG_STATUS, `STAT_ACTIVE_BIT, 1'b0);
            check("dc balance", 32'h0, dc_sum);
            bus(1'b0, `REG_INT_STATUS, 8'h00);
            check("shutdown int", 32'h1, rd);
            check("irq masked", 32'h0, 32'(irq));
            bus(1'b1, `REG_INT_STATUS, 8'h01);
            $display("test mode %0d done", m);
        end
        bus(1'b1, `REG_INT_MASK, 8'h03);
        bus(1'b1, `REG_CONTROL, 8'h97);
        poll(`REG_STATUS, `STAT_ACTIVE_BIT, 1'b1);
        bus(1'b1, 5'h05, 8'haa);
        bus(1'b0, 5'h05, 8'h00);
        check("write dropped", 32'h0, rd);
        bus(1'b0, `REG_STATUS, 8'h00);
        check("write error", 32'h3, rd);
        poll(`REG_INT_STATUS, `INT_FRAME_BIT, 1'b1);
        bus(1'b1, 5'h05, 8'h55);
        bus(1'b0, 5'h05, 8'h00);
        check("write in window", 32'h55, rd);
        check("irq frame", 32'h1, 32'(irq));
        bus(1'b1, `REG_STATUS, 8'h02);
        bus(1'b0, `REG_STATUS, 8'h00);
        check("write error clear", 32'h1, rd);
        bus(1'b1, `REG_INT_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        check("irq mask off", 32'h0, 32'(irq));
        bus(1'b1, `REG_CONTROL, 8'h17);
        poll(`REG_STATUS, `STAT_ACTIVE_BIT, 1'b0);
        bus(1'b1, `REG_INT_STATUS, 8'h03);
        $display("test type b done");
        // all pixels clear in static drive: no pixel carries dc, so sleep is safe
        dc_clear <= 1'b1;
        bus(1'b1, 5'h00, 8'h00);
        dc_clear <= 1'b0;
        bus(1'b1, `REG_CONTROL, 8'h80);
        poll(`REG_STATUS, `STAT_ACTIVE_BIT, 1'b1);
        check("drive running", 32'h0, 32'(lcd_drive === '0));
        sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("sleep stop", 32'h1, 32'(lcd_drive === '0));
        check("sleep dc", 32'h0, dc_sum);
        bus(1'b0, `REG_INT_STATUS, 8'h00);
        check("sleep shutdown", 32'h1, rd & 32'h1);
        sleep_req <= 1'b0;
        $display("test sleep done");
        tally_and_finish();
    end
endmodule
